// ### logic/dis_pkg.sv
/*
 diagnostic indicator package: colours, display modes, backplane error codes, timing.
 assumes a 200 MHz clock and a synchronous active-low reset.
*/
package dis_pkg;
  localparam int CLK_HZ = 200000000;
  // hold and start-up times, printed figure in seconds
  localparam int FW_SHOW_S = 3;
  localparam int HOLD_S = 3;
  localparam int FW_SHOW_CYC = FW_SHOW_S * CLK_HZ;
  localparam int HOLD_CYC = HOLD_S * CLK_HZ;
  // flash half period in ms (own figure, no cadence given)
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);

  typedef enum logic [1:0] {
    COL_OFF = 2'b00,
    COL_GREEN = 2'b01,
    COL_ORANGE = 2'b10,
    COL_RED = 2'b11
  } dis_colour_t;

  typedef enum logic [2:0] {
    DSP_FW_VERSION = 3'b000,
    DSP_STATUS = 3'b001,
    DSP_CONFIG = 3'b010,
    DSP_FW_FAULT = 3'b011,
    DSP_MENU_PAGE = 3'b100,
    DSP_BP_ERROR = 3'b101
  } dis_disp_t;

  // backplane error codes
  localparam logic [7:0] BPE_EMC = 8'h00;
  localparam logic [7:0] BPE_TABLE = 8'h01;
  localparam logic [7:0] BPE_RESERVED = 8'h02;
  localparam logic [7:0] BPE_COMMAND = 8'h03;
  localparam logic [7:0] BPE_BREAK = 8'h04;
  localparam logic [7:0] BPE_REGCOM = 8'h05;
  // table error arguments, then the config display tag byte
  localparam logic [7:0] ARG_CHECKSUM = 8'h00;
  localparam logic [7:0] ARG_OVERFLOW = 8'h01;
  localparam logic [7:0] ARG_DATATYPE = 8'h02;
  localparam logic [7:0] CFG_TAG_HI = 8'hf0;

  localparam logic [2:0] MENU_PAGES = 3'h4;
  localparam logic [2:0] MENU_BP_PAGE = 3'h3;
endpackage

// ### logic/dis_flash_if.sv
/*
 interface carrying the shared flash phase from the divider to the indicator logic.
 assumes one clock domain.
*/
`timescale 1ns/1ps
interface dis_flash_if;
  logic phase;
  modport src (output phase);
  modport dst (input phase);
endinterface

// ### logic/dis_flash_div.sv
/*
 flash divider: toggles one common on/off phase every half period.
 assumes the main clock and synchronous active-low reset.
*/
`timescale 1ns/1ps
module dis_flash_div #(
  // configurable so a bench can run whole flash periods in a short run
  parameter int HALF_CYC = dis_pkg::FLASH_HALF_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  dis_flash_if.src fl
);
  logic [31:0] cnt_q, cnt_d;
  logic ph_q, ph_d;

  always_comb begin
    cnt_d = cnt_q + 32'h1;
    ph_d = ph_q;
    if (cnt_q == 32'(HALF_CYC - 1)) begin
      cnt_d = '0;
      ph_d = ~ph_q;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cnt_q <= '0;
      ph_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      ph_q <= ph_d;
    end
  end

  assign fl.phase = ph_q;

  a_flash_period: assert property (@(posedge clock) disable iff (!reset_n)
    (cnt_q == 32'(HALF_CYC - 1)) |=> (ph_q != $past(ph_q)))
    else $error("flash phase did not toggle at half period");
endmodule

// ### logic/dis_indicator.sv
/*
 diagnostic indicator logic: fieldbus, program and backplane lamps, text display
 and joystick setup menu showing backplane error code and argument.
 assumes status inputs synchronous to clock; lamps and display decode outputs.
*/
`timescale 1ns/1ps
module dis_indicator #(
  parameter int FW_SHOW_CYC = dis_pkg::FW_SHOW_CYC,
  parameter int HOLD_CYC = dis_pkg::HOLD_CYC,
  parameter int FLASH_HALF_CYC = dis_pkg::FLASH_HALF_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  // start-up configuration check
  input wire logic cfg_check_done,
  input wire logic cfg_check_ok,
  input wire logic [7:0] cfg_bad_position,
  input wire logic fw_fault,
  input wire logic [15:0] fw_fault_code,
  input wire logic [15:0] fw_version,
  // fieldbus status
  input wire logic fb_attached,
  input wire logic fb_supply_ok,
  input wire logic fb_comm_error,
  input wire logic fb_baud_search,
  input wire logic fb_master_seen,
  input wire logic fb_comm_active,
  // program status
  input wire logic prg_running,
  input wire logic prg_loaded,
  input wire logic prg_overrun_some,
  input wire logic prg_overrun_all,
  input wire logic prg_boot_project,
  input wire logic prg_boot_generating,
  input wire logic prg_in_cycle,
  // backplane status
  input wire logic bp_exchanging,
  input wire logic bp_reg_access,
  input wire logic bp_error,
  input wire logic [7:0] bp_err_code,
  input wire logic [7:0] bp_err_arg,
  // joystick
  input wire logic joy_press,
  input wire logic joy_left,
  input wire logic joy_right,
  // outputs
  output dis_pkg::dis_colour_t fb_colour,
  output logic fb_flash,
  output dis_pkg::dis_colour_t prg_colour,
  output logic prg_flash,
  output dis_pkg::dis_colour_t bp_colour,
  output logic bp_flash,
  output dis_pkg::dis_disp_t disp_mode,
  output logic [15:0] disp_value,
  output logic [7:0] disp_err_code,
  output logic [7:0] disp_err_arg,
  output logic menu_active,
  output logic [2:0] menu_page
);
  dis_flash_if fl ();
  dis_flash_div #(.HALF_CYC(FLASH_HALF_CYC)) u_div (
    .clock(clock),
    .reset_n(reset_n),
    .fl(fl)
  );

  typedef enum logic [1:0] {
    ST_FW_SHOW = 2'b00,
    ST_CHECK = 2'b01,
    ST_RUN = 2'b10,
    ST_CFG_FAIL = 2'b11
  } dis_start_t;

  // code 2 is reserved and never shown on the display as a real fault
  function automatic logic valid_code(input logic [7:0] c);
    valid_code = (c <= dis_pkg::BPE_REGCOM) && (c != dis_pkg::BPE_RESERVED);
  endfunction

  dis_start_t st_q, st_d;
  logic [31:0] tmr_q, tmr_d;
  logic [31:0] hold_q, hold_d;
  logic hold_fired_q, hold_fired_d;
  logic menu_q, menu_d;
  logic [2:0] page_q, page_d;
  logic left_q, right_q;
  logic [7:0] cfg_pos_q, cfg_pos_d;

  // start-up sequencer and menu
  always_comb begin
    st_d = st_q;
    tmr_d = tmr_q;
    cfg_pos_d = cfg_pos_q;
    unique case (st_q)
      ST_FW_SHOW: begin
        tmr_d = tmr_q + 32'h1;
        if (tmr_q == 32'(FW_SHOW_CYC - 1)) begin
          st_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (cfg_check_done) begin
          if (cfg_check_ok) begin
            st_d = ST_RUN;
          end else begin
            st_d = ST_CFG_FAIL;
            cfg_pos_d = cfg_bad_position;
          end
        end
      end
      ST_RUN: begin
      end
      ST_CFG_FAIL: begin
      end
    endcase
    // press held long enough toggles the menu once per hold
    hold_d = joy_press ? hold_q + 32'h1 : 32'h0;
    hold_fired_d = joy_press ? hold_fired_q : 1'b0;
    menu_d = menu_q;
    page_d = page_q;
    if (joy_press && !hold_fired_q && hold_q == 32'(HOLD_CYC - 1)) begin
      hold_fired_d = 1'b1;
      menu_d = ~menu_q;
      page_d = '0;
      hold_d = 32'h0;
    end else if (menu_q && joy_right && !right_q) begin
      page_d = (page_q == dis_pkg::MENU_PAGES - 3'h1) ? 3'h0 : page_q + 3'h1;
    end else if (menu_q && joy_left && !left_q) begin
      page_d = (page_q == 3'h0) ? dis_pkg::MENU_PAGES - 3'h1 : page_q - 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_q <= ST_FW_SHOW;
      tmr_q <= '0;
      hold_q <= '0;
      hold_fired_q <= 1'b0;
      menu_q <= 1'b0;
      page_q <= '0;
      left_q <= 1'b0;
      right_q <= 1'b0;
      cfg_pos_q <= '0;
    end else begin
      st_q <= st_d;
      tmr_q <= tmr_d;
      hold_q <= hold_d;
      hold_fired_q <= hold_fired_d;
      menu_q <= menu_d;
      page_q <= page_d;
      left_q <= joy_left;
      right_q <= joy_right;
      cfg_pos_q <= cfg_pos_d;
    end
  end

  // lamp and display decode, registered
  dis_pkg::dis_colour_t fbc_d, prc_d, bpc_d;
  logic fbf_d, prf_d, bpf_d;
  dis_pkg::dis_disp_t dm_d;
  logic [15:0] dv_d;
  logic [7:0] dc_d, da_d;

  always_comb begin
    // fieldbus lamp
    fbc_d = dis_pkg::COL_OFF;
    fbf_d = 1'b0;
    if (!fb_supply_ok && fb_attached) begin
      fbc_d = dis_pkg::COL_RED;
    end else if (!fb_attached) begin
      fbc_d = dis_pkg::COL_OFF;
    end else if (fb_comm_error) begin
      fbc_d = dis_pkg::COL_RED;
      fbf_d = 1'b1;
    end else if (fb_baud_search) begin
      fbc_d = dis_pkg::COL_ORANGE;
      fbf_d = 1'b1;
    end else if (!fb_master_seen) begin
      fbc_d = dis_pkg::COL_GREEN;
      fbf_d = 1'b1;
    end else if (fb_comm_active) begin
      fbc_d = dis_pkg::COL_GREEN;
    end
    // program lamp
    prc_d = dis_pkg::COL_OFF;
    prf_d = 1'b0;
    if (!prg_running || !prg_loaded) begin
      prc_d = dis_pkg::COL_OFF;
    end else if (prg_overrun_all) begin
      prc_d = dis_pkg::COL_RED;
    end else if (prg_overrun_some) begin
      prc_d = dis_pkg::COL_RED;
      prf_d = 1'b1;
    end else if (prg_boot_generating) begin
      prc_d = dis_pkg::COL_ORANGE;
      prf_d = 1'b1;
    end else if (prg_in_cycle) begin
      prc_d = prg_boot_project ? dis_pkg::COL_GREEN : dis_pkg::COL_ORANGE;
    end
    // backplane lamp
    bpc_d = dis_pkg::COL_OFF;
    bpf_d = 1'b0;
    if (st_q == ST_CFG_FAIL) begin
      bpc_d = dis_pkg::COL_RED;
      bpf_d = 1'b1;
    end else if (st_q != ST_RUN) begin
      bpc_d = dis_pkg::COL_OFF;
    end else if (bp_error || fw_fault) begin
      bpc_d = dis_pkg::COL_RED;
    end else if (bp_reg_access) begin
      bpc_d = dis_pkg::COL_ORANGE;
    end else if (bp_exchanging) begin
      bpc_d = dis_pkg::COL_GREEN;
    end
    // display
    dm_d = dis_pkg::DSP_STATUS;
    dv_d = 16'h0;
    dc_d = 8'h0;
    da_d = 8'h0;
    if (menu_q) begin
      dm_d = dis_pkg::DSP_MENU_PAGE;
      dv_d = {13'h0, page_q};
      if (page_q == dis_pkg::MENU_BP_PAGE && bp_error && valid_code(bp_err_code)) begin
        dm_d = dis_pkg::DSP_BP_ERROR;
        dc_d = bp_err_code;
        // emc fault carries no argument
        da_d = (bp_err_code == dis_pkg::BPE_EMC) ? 8'h0 : bp_err_arg;
      end
    end else if (st_q == ST_FW_SHOW) begin
      dm_d = dis_pkg::DSP_FW_VERSION;
      dv_d = fw_version;
    end else if (fw_fault) begin
      dm_d = dis_pkg::DSP_FW_FAULT;
      dv_d = fw_fault_code;
    end else if (st_q == ST_CFG_FAIL) begin
      dm_d = dis_pkg::DSP_CONFIG;
      dv_d = {dis_pkg::CFG_TAG_HI, cfg_pos_q};
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      fb_colour <= dis_pkg::COL_OFF;
      fb_flash <= 1'b0;
      prg_colour <= dis_pkg::COL_OFF;
      prg_flash <= 1'b0;
      bp_colour <= dis_pkg::COL_OFF;
      bp_flash <= 1'b0;
      disp_mode <= dis_pkg::DSP_FW_VERSION;
      disp_value <= '0;
      disp_err_code <= '0;
      disp_err_arg <= '0;
      menu_active <= 1'b0;
      menu_page <= '0;
    end else begin
      // flashing lamps blank on the off half of the common phase
      fb_colour <= (fbf_d && !fl.phase) ? dis_pkg::COL_OFF : fbc_d;
      fb_flash <= fbf_d;
      prg_colour <= (prf_d && !fl.phase) ? dis_pkg::COL_OFF : prc_d;
      prg_flash <= prf_d;
      bp_colour <= (bpf_d && !fl.phase) ? dis_pkg::COL_OFF : bpc_d;
      bp_flash <= bpf_d;
      disp_mode <= dm_d;
      disp_value <= dv_d;
      disp_err_code <= dc_d;
      disp_err_arg <= da_d;
      menu_active <= menu_q;
      menu_page <= page_q;
    end
  end

  a_fw_show_len: assert property (@(posedge clock) disable iff (!reset_n)
    (st_q == ST_FW_SHOW && tmr_q < 32'(FW_SHOW_CYC - 1)) |=> st_q == ST_FW_SHOW)
    else $error("firmware version left early");
  a_check_ok_off: assert property (@(posedge clock) disable iff (!reset_n)
    (st_q == ST_CHECK && cfg_check_done && cfg_check_ok) |=> st_q == ST_RUN)
    else $error("good check did not reach run");
  a_cfg_tag_shown: assert property (@(posedge clock) disable iff (!reset_n)
    (st_q == ST_CFG_FAIL && !menu_q && !fw_fault) |=> disp_value[15:8] == 8'hf0)
    else $error("config tag missing");
  a_fb_no_bus: assert property (@(posedge clock) disable iff (!reset_n)
    (!fb_attached && fb_supply_ok) |=> fb_colour == dis_pkg::COL_OFF)
    else $error("fieldbus lamp lit with no bus");
  a_fb_active_green: assert property (@(posedge clock) disable iff (!reset_n)
    (fb_attached && fb_supply_ok && !fb_comm_error && !fb_baud_search && fb_master_seen
     && fb_comm_active) |=> (fb_colour == dis_pkg::COL_GREEN && !fb_flash))
    else $error("active fieldbus not steady green");
  a_prg_stop_off: assert property (@(posedge clock) disable iff (!reset_n)
    !prg_running |=> prg_colour == dis_pkg::COL_OFF)
    else $error("program lamp lit when stopped");
  a_prg_all_red: assert property (@(posedge clock) disable iff (!reset_n)
    (prg_running && prg_loaded && prg_overrun_all) |=> (prg_colour == dis_pkg::COL_RED
     && !prg_flash))
    else $error("full overrun not steady red");
  a_menu_toggle: assert property (@(posedge clock) disable iff (!reset_n)
    (joy_press && !hold_fired_q && hold_q == 32'(HOLD_CYC - 1)) |=> menu_q != $past(menu_q))
    else $error("held press did not toggle menu");
  a_bp_reserved: assert property (@(posedge clock) disable iff (!reset_n)
    disp_mode == dis_pkg::DSP_BP_ERROR |-> disp_err_code != dis_pkg::BPE_RESERVED)
    else $error("reserved code shown");
endmodule

// ### sim/dis_panel_model.sv
/*
 joystick side of the operator panel: press-and-hold and left/right nudges.
 assumes calls start just after a rising clock edge; levels change 1 ns after an edge.
*/
`timescale 1ns/1ps
module dis_panel_model #(
  parameter int HOLD_CYC = 10
) (
  input wire logic clock,
  output logic joy_press,
  output logic joy_left,
  output logic joy_right
);
  initial begin
    joy_press = 1'b0;
    joy_left = 1'b0;
    joy_right = 1'b0;
  end

  // operator holds past the hold time, then lets go so the next toggle can arm
  task automatic hold_press();
    joy_press = 1'b1;
    repeat (HOLD_CYC + 2) @(posedge clock);
    #1 joy_press = 1'b0;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // one short nudge; menu outputs trail the edge by two cycles
  task automatic nudge(input logic right);
    if (right) begin
      joy_right = 1'b1;
    end else begin
      joy_left = 1'b1;
    end
    @(posedge clock);
    #1 joy_right = 1'b0;
    joy_left = 1'b0;
    repeat (3) @(posedge clock);
    #1;
  endtask
endmodule

// ### sim/test_dis_indicator.sv
/*
 self-checking bench for the diagnostic indicator block.
 assumes shortened start-up, hold and flash counts; flashing lamps are watched a full period.
*/
`timescale 1ns/1ps
module test_dis_indicator;
  localparam int FW = 20;
  localparam int HOLD = 10;
  localparam int FLASH = 4;
  logic clock, reset_n, cfg_done, cfg_ok, fw_fault, bp_err;
  logic [7:0] cfg_pos, bp_code, bp_arg;
  logic [15:0] fw_code;
  logic [5:0] fb_in;
  logic [6:0] prg_in;
  logic [1:0] bp_in;
  logic joy_press, joy_left, joy_right, fb_flash, prg_flash, bp_flash, menu_active;
  dis_pkg::dis_colour_t fb_colour, prg_colour, bp_colour;
  dis_pkg::dis_disp_t disp_mode;
  logic [15:0] disp_value;
  logic [7:0] disp_err_code, disp_err_arg;
  logic [2:0] menu_page;
  int miscompares = 0;
  int check_count = 0;

  dis_indicator #(.FW_SHOW_CYC(FW), .HOLD_CYC(HOLD), .FLASH_HALF_CYC(FLASH)) uut (
    .clock(clock), .reset_n(reset_n), .cfg_check_done(cfg_done), .cfg_check_ok(cfg_ok),
    .cfg_bad_position(cfg_pos), .fw_fault(fw_fault), .fw_fault_code(fw_code),
    .fw_version(16'h1234), .fb_attached(fb_in[5]), .fb_supply_ok(fb_in[4]),
    .fb_comm_error(fb_in[3]), .fb_baud_search(fb_in[2]), .fb_master_seen(fb_in[1]),
    .fb_comm_active(fb_in[0]), .prg_running(prg_in[6]), .prg_loaded(prg_in[5]),
    .prg_overrun_some(prg_in[4]), .prg_overrun_all(prg_in[3]),
    .prg_boot_project(prg_in[2]), .prg_boot_generating(prg_in[1]),
    .prg_in_cycle(prg_in[0]), .bp_exchanging(bp_in[1]), .bp_reg_access(bp_in[0]),
    .bp_error(bp_err), .bp_err_code(bp_code), .bp_err_arg(bp_arg),
    .joy_press(joy_press), .joy_left(joy_left), .joy_right(joy_right),
    .fb_colour(fb_colour), .fb_flash(fb_flash), .prg_colour(prg_colour),
    .prg_flash(prg_flash), .bp_colour(bp_colour), .bp_flash(bp_flash),
    .disp_mode(disp_mode), .disp_value(disp_value), .disp_err_code(disp_err_code),
    .disp_err_arg(disp_err_arg), .menu_active(menu_active), .menu_page(menu_page)
  );

  dis_panel_model #(.HOLD_CYC(HOLD)) panel (
    .clock(clock), .joy_press(joy_press), .joy_left(joy_left), .joy_right(joy_right)
  );

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // one full flash period: steady lamps never change, flashing ones are lit exactly half of it
  task automatic lamp(input int sel, input logic [1:0] col, input logic fl);
    logic [2:0] v;
    logic bad;
    int nlit;
    bad = 1'b0;
    nlit = 0;
    for (int i = 0; i < 2 * FLASH; i++) begin
      cyc(1);
      v = (sel == 0) ? {fb_colour, fb_flash} : (sel == 1) ? {prg_colour, prg_flash}
        : {bp_colour, bp_flash};
      if (v === {col, fl}) begin
        nlit++;
      end else if (!fl || v !== {dis_pkg::COL_OFF, 1'b1}) begin
        bad = 1'b1;
      end
    end
    chk(bad, 1'b0);
    chk(nlit, fl ? FLASH : 2 * FLASH);
  endtask

  task automatic stop_test();
    if (miscompares == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic do_reset(input logic ok);
    reset_n = 1'b0;
    cfg_done = 1'b1;
    cfg_ok = ok;
    repeat (4) @(posedge clock);
    #1 reset_n = 1'b1;
  endtask

  // version first, status only after the start-up interval
  task automatic t_startup();
    cyc(2);
    chk({disp_mode, disp_value}, {dis_pkg::DSP_FW_VERSION, 16'h1234});
    cyc(FW - 2);
    chk(disp_mode, dis_pkg::DSP_FW_VERSION);
    cyc(1);
    chk(disp_mode, dis_pkg::DSP_STATUS);
    cyc(2);
    chk({bp_colour, bp_flash}, {dis_pkg::COL_OFF, 1'b0});
  endtask

  // flashing states must show their own colour, not only the dark half
  task automatic t_fieldbus();
    logic [5:0] st [7] = '{6'h00, 6'h10, 6'h20, 6'h38, 6'h34, 6'h30, 6'h33};
    logic [2:0] ex [7] = '{{dis_pkg::COL_OFF, 1'b0}, {dis_pkg::COL_OFF, 1'b0},
      {dis_pkg::COL_RED, 1'b0}, {dis_pkg::COL_RED, 1'b1}, {dis_pkg::COL_ORANGE, 1'b1},
      {dis_pkg::COL_GREEN, 1'b1}, {dis_pkg::COL_GREEN, 1'b0}};
    for (int i = 0; i < 7; i++) begin
      fb_in = st[i];
      lamp(0, ex[i][2:1], ex[i][0]);
    end
  endtask

  task automatic t_program();
    logic [6:0] st [8] = '{7'h21, 7'h41, 7'h79, 7'h71, 7'h63, 7'h61, 7'h65, 7'h64};
    logic [2:0] ex [8] = '{{dis_pkg::COL_OFF, 1'b0}, {dis_pkg::COL_OFF, 1'b0},
      {dis_pkg::COL_RED, 1'b0}, {dis_pkg::COL_RED, 1'b1}, {dis_pkg::COL_ORANGE, 1'b1},
      {dis_pkg::COL_ORANGE, 1'b0}, {dis_pkg::COL_GREEN, 1'b0}, {dis_pkg::COL_OFF, 1'b0}};
    for (int i = 0; i < 8; i++) begin
      prg_in = st[i];
      lamp(1, ex[i][2:1], ex[i][0]);
    end
  endtask

  task automatic t_backplane();
    logic [2:0] st [5] = '{3'b000, 3'b100, 3'b110, 3'b101, 3'b111};
    logic [1:0] ex [5] = '{dis_pkg::COL_OFF, dis_pkg::COL_GREEN, dis_pkg::COL_ORANGE,
      dis_pkg::COL_RED, dis_pkg::COL_RED};
    bp_code = 8'h03;
    for (int i = 0; i < 5; i++) begin
      {bp_in, bp_err} = st[i];
      lamp(2, ex[i], 1'b0);
    end
    {bp_in, bp_err} = 3'b100;
  endtask

  task automatic t_menu();
    logic [15:0] ok_in [8] = '{16'h0005, 16'h0100, 16'h0101, 16'h0102, 16'h0300,
      16'h0400, 16'h0409, 16'h0503};
    logic [15:0] bad_in [2] = '{16'h0200, 16'h0601};
    panel.nudge(1'b1);
    chk({menu_active, menu_page}, 4'h0);
    panel.hold_press();
    chk({menu_active, menu_page}, 4'h8);
    for (int i = 1; i < 4; i++) begin
      panel.nudge(1'b1);
      chk(menu_page, i);
    end
    panel.nudge(1'b0);
    chk(menu_page, 3'h2);
    panel.nudge(1'b1);
    chk({menu_page, disp_mode}, {3'h3, dis_pkg::DSP_MENU_PAGE});
    bp_err = 1'b1;
    for (int i = 0; i < 8; i++) begin
      {bp_code, bp_arg} = ok_in[i];
      cyc(3);
      chk({disp_mode, disp_err_code, disp_err_arg}, {dis_pkg::DSP_BP_ERROR, ok_in[i][15:8],
        (ok_in[i][15:8] == 8'h00) ? 8'h00 : ok_in[i][7:0]});
    end
    for (int i = 0; i < 2; i++) begin
      {bp_code, bp_arg} = bad_in[i];
      cyc(3);
      chk(disp_mode, dis_pkg::DSP_MENU_PAGE);
    end
    bp_err = 1'b0;
    panel.hold_press();
    chk({menu_active, disp_mode}, {1'b0, dis_pkg::DSP_STATUS});
  endtask

  task automatic t_faults();
    fw_fault = 1'b1;
    fw_code = 16'h5a3c;
    cyc(3);
    chk({disp_mode, disp_value}, {dis_pkg::DSP_FW_FAULT, 16'h5a3c});
    chk({bp_colour, bp_flash}, {dis_pkg::COL_RED, 1'b0});
    fw_fault = 1'b0;
    cfg_pos = 8'h07;
    do_reset(1'b0);
    cyc(FW + 6);
    chk({disp_mode, disp_value}, {dis_pkg::DSP_CONFIG, 16'hf007});
    lamp(2, dis_pkg::COL_RED, 1'b1);
  endtask

  initial begin
    reset_n = 1'b0;
    cfg_done = 1'b0;
    cfg_ok = 1'b0;
    cfg_pos = 8'h00;
    fw_fault = 1'b0;
    fw_code = 16'h0000;
    fb_in = 6'h00;
    prg_in = 7'h00;
    bp_in = 2'b00;
    bp_err = 1'b0;
    bp_code = 8'h00;
    bp_arg = 8'h00;
    do_reset(1'b1);
    t_startup();
    t_fieldbus();
    t_program();
    t_backplane();
    t_menu();
    t_faults();
    stop_test();
  end

  // the sequence takes a few hundred cycles; this margin only catches a hang
  initial begin
    repeat (20000) @(posedge clock);
    miscompares++;
    stop_test();
  end
endmodule
